// ### core/pwr_seq_regs.svh
// Timing constants for the power on/off sequencer
`ifndef PWR_SEQ_REGS_SVH
`define PWR_SEQ_REGS_SVH
`define CLK_HZ           125000000
`define CYC_PER_MS       (`CLK_HZ / 1000)
`define T_DETECT_MS      250
`define T_MIN_LOW_MS     685
`define T_PULSE_MS       135
`define T_IRST_MS        38
`define T_READY_MS       5000
`define T_HWOFF_MS       5500
`define MS_W             13
`endif

// ### core/pwr_seq_pkg.sv
// Types shared by the power sequencer files
package pwr_seq_pkg;
  typedef enum logic [2:0] {
    ST_WAIT_BATT,
    ST_OFF,
    ST_PRESS,
    ST_BOOT,
    ST_ON,
    ST_OFF_PROC,
    ST_OFF_WAIT
  } seq_state_t;
endpackage : pwr_seq_pkg

// ### core/ms_tick_if.sv
// Millisecond tick carried from the timebase to the sequencer
`timescale 1ns/1ps
interface ms_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : ms_tick_if

// ### core/ms_timebase.sv
// Divider producing a one-cycle pulse every millisecond
`timescale 1ns/1ps
`include "pwr_seq_regs.svh"
module ms_timebase #(
  parameter int CYC_PER_MS = `CYC_PER_MS
) (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  ms_tick_if.src    tb
);
  logic [31:0] cnt_q;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q   <= 32'h0;
      tb.tick <= 1'b0;
    end else if (cnt_q == 32'(CYC_PER_MS - 1)) begin
      cnt_q   <= 32'h0;
      tb.tick <= 1'b1;
    end else begin
      cnt_q   <= cnt_q + 32'h1;
      tb.tick <= 1'b0;
    end
  end
endmodule : ms_timebase

// ### core/pwr_sequencer.sv
// Power on/off sequencer for the modem module
`timescale 1ns/1ps
`include "pwr_seq_regs.svh"
// Summary of operation
// - Switch input idles high; a low level requests power-on.
// - Switch input is ignored until 250 ms after the battery supply appears.
// - Ready goes high for 135 ms at the start of the press, then low.
// - An internal reset of 38 ms is applied during power-on.
// - Ready rises 5 s after the power-on request, inside the 4 to 7 s window.
// - A software power-off command starts power-off processing.
// - Switch still low at command processing keeps the module on.
// - Switch held low 5.5 s while on issues the power-off command internally.
// - Power-off processing deregisters and drives ready low.
// - Switch-off completes only once the switch input is high.
// - Ready is low before the logic supply is removed.
module pwr_sequencer
  import pwr_seq_pkg::*;
#(
  parameter int CYC_PER_MS = `CYC_PER_MS
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_i,
  // Host pins
  input  wire logic pwr_switch_n_i,
  output logic      module_ready_ind_o,
  output logic      logic_supply_out_o,
  output logic      int_reset_o,
  // Command side
  input  wire logic power_off_command_i,
  input  wire logic dereg_done_i,
  output logic      dereg_req_o
);
  ms_tick_if tb ();
  ms_timebase #(.CYC_PER_MS(CYC_PER_MS)) u_tb (
    .mclk_i (mclk_i),
    .reset_i(reset_i),
    .tb     (tb)
  );

  seq_state_t      state_q;
  logic [`MS_W-1:0] ms_q;
  logic [`MS_W-1:0] low_ms_q;
  logic             cmd_pend_q;
  logic             hw_off_q;

  // Supply decode, shared by the output register and its checks
  function automatic logic is_powered(input seq_state_t s);
    return s inside {ST_PRESS, ST_BOOT, ST_ON, ST_OFF_PROC};
  endfunction : is_powered

  // Battery reset doubles as power-on reset, so the 250 ms counts from its release
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_WAIT_BATT;
      ms_q    <= '0;
    end else begin
      unique case (state_q)
        ST_WAIT_BATT: begin
          if (tb.tick) ms_q <= ms_q + 1'b1;
          if (ms_q == `MS_W'(`T_DETECT_MS)) begin
            state_q <= ST_OFF;
            ms_q    <= '0;
          end
        end
        ST_OFF: begin
          ms_q <= '0;
          if (!pwr_switch_n_i) state_q <= ST_PRESS;
        end
        ST_PRESS: begin
          if (tb.tick) ms_q <= ms_q + 1'b1;
          if (pwr_switch_n_i) state_q <= ST_OFF;
          else if (ms_q == `MS_W'(`T_MIN_LOW_MS)) state_q <= ST_BOOT;
        end
        ST_BOOT: begin
          if (tb.tick) ms_q <= ms_q + 1'b1;
          if (ms_q == `MS_W'(`T_READY_MS)) state_q <= ST_ON;
        end
        ST_ON: begin
          ms_q <= '0;
          // A long press must not wait for release, the switch is still held low here
          if (hw_off_q) begin
            state_q <= ST_OFF_PROC;
          end else if (cmd_pend_q && pwr_switch_n_i) begin
            state_q <= ST_OFF_PROC;
          end
        end
        ST_OFF_PROC: begin
          if (dereg_done_i) state_q <= ST_OFF_WAIT;
        end
        ST_OFF_WAIT: begin
          if (pwr_switch_n_i) state_q <= ST_OFF;
        end
      endcase
    end
  end

  // Long-press detector; runs only while on and re-arms on release
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      low_ms_q <= '0;
    end else if (state_q != ST_ON || pwr_switch_n_i) begin
      low_ms_q <= '0;
    end else if (tb.tick && low_ms_q != `MS_W'(`T_HWOFF_MS)) begin
      low_ms_q <= low_ms_q + 1'b1;
    end
  end

  // Command pending; a command with the switch still low is dropped so the module stays on
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_pend_q <= 1'b0;
    end else if (state_q != ST_ON) begin
      cmd_pend_q <= 1'b0;
    end else if (power_off_command_i) begin
      cmd_pend_q <= 1'b1;
    end else if (cmd_pend_q && !pwr_switch_n_i) begin
      cmd_pend_q <= 1'b0;
    end
  end

  // Internally issued power-off after a long press; kept apart from the software
  // command so that the switch-low drop does not swallow it
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      hw_off_q <= 1'b0;
    end else if (state_q != ST_ON) begin
      hw_off_q <= 1'b0;
    end else if (low_ms_q == `MS_W'(`T_HWOFF_MS - 1) && tb.tick) begin
      hw_off_q <= 1'b1;
    end
  end

  // Outputs
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      module_ready_ind_o <= 1'b0;
      logic_supply_out_o <= 1'b0;
      int_reset_o        <= 1'b0;
      dereg_req_o        <= 1'b0;
    end else begin
      module_ready_ind_o <= (state_q == ST_PRESS && ms_q < `MS_W'(`T_PULSE_MS))
                            || state_q == ST_ON;
      logic_supply_out_o <= is_powered(state_q) || (state_q == ST_OFF_WAIT && !pwr_switch_n_i);
      int_reset_o        <= state_q == ST_BOOT && ms_q < `MS_W'(`T_MIN_LOW_MS + `T_IRST_MS);
      dereg_req_o        <= state_q == ST_OFF_PROC;
    end
  end

  a_detect_wait: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == ST_WAIT_BATT |=> state_q inside {ST_WAIT_BATT, ST_OFF})
    else $error("switch sampled before detect delay");
  a_short_press: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == ST_PRESS && pwr_switch_n_i |=> state_q == ST_OFF)
    else $error("short press did not return to off");
  a_boot_entry: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == ST_PRESS ##1 state_q == ST_BOOT |-> $past(ms_q) == `MS_W'(`T_MIN_LOW_MS))
    else $error("boot entered before minimum low time");
  a_ready_pulse: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(state_q == ST_PRESS) |=> module_ready_ind_o)
    else $error("ready pulse missing at press start");
  a_ready_on: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == ST_ON |=> module_ready_ind_o)
    else $error("ready not high while on");
  a_cmd_low: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == ST_ON && !pwr_switch_n_i && !hw_off_q |=> state_q != ST_OFF_PROC)
    else $error("power-off processed with switch low");
  a_ready_off: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == ST_OFF_PROC |=> !module_ready_ind_o && dereg_req_o)
    else $error("ready high during power-off processing");
  a_off_high: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == ST_OFF_WAIT ##1 state_q == ST_OFF |-> $past(pwr_switch_n_i))
    else $error("switch-off completed with switch low");
  a_supply_drop: assert property (@(posedge mclk_i) disable iff (reset_i)
    $fell(logic_supply_out_o) |-> !module_ready_ind_o)
    else $error("supply removed while ready high");

  a_hw_off: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == ST_ON && hw_off_q |=> state_q == ST_OFF_PROC)
    else $error("long press did not start power-off");

  a_irst_boot: assert property (@(posedge mclk_i) disable iff (reset_i)
    int_reset_o |-> $past(state_q == ST_BOOT))
    else $error("internal reset outside boot");

  a_supply_on: assert property (@(posedge mclk_i) disable iff (reset_i)
    is_powered(state_q) |=> logic_supply_out_o)
    else $error("supply off while powered");

  a_off_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == ST_OFF_WAIT && !pwr_switch_n_i |=> logic_supply_out_o)
    else $error("supply removed with switch low");

  a_ready_boot: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == ST_BOOT |=> !module_ready_ind_o)
    else $error("ready high during boot");
endmodule : pwr_sequencer

// ### bench/host_model.sv
// Host side: open-collector switch driver and network deregistration responder
`timescale 1ns/1ps
module host_model #(
  parameter int DEREG_LAT = 20
) (
  input  wire logic mclk_i,
  input  wire logic pull_low_i,
  input  wire logic dereg_req_i,
  output logic      pwr_switch_n_o,
  output logic      dereg_done_o
);
  int cnt_q;
  // Released transistor leaves the line to the pull-up, never floating
  assign pwr_switch_n_o = !pull_low_i;
  always_ff @(posedge mclk_i) begin
    cnt_q        <= dereg_req_i ? cnt_q + 1 : 0;
    dereg_done_o <= dereg_req_i && cnt_q >= DEREG_LAT;
  end
endmodule : host_model

// ### bench/pwr_sequencer_test.sv
// Self-checking bench for the power on/off sequencer
`timescale 1ns/1ps
`include "pwr_seq_regs.svh"
module pwr_sequencer_test;
  localparam int CPM = 2;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        pull_low = 1'b0;
  logic        cmd = 1'b0;
  logic        sw_n, rdy, sup, irst, done, dreq;
  logic        rdy_w, sup_w, irst_w, dreq_w;
  logic [15:0] lfsr = 16'h775E;
  int          err_total = 0;
  int          num_checks = 0;
  int          pts[$] = '{50, 200, 700, 760, 4900, 5100};
  always #4 mclk_i = ~mclk_i;
  // Outputs are settled copies taken mid-cycle, so checks at an edge never race the launch
  always @(negedge mclk_i) begin
    rdy  <= rdy_w;
    sup  <= sup_w;
    irst <= irst_w;
    dreq <= dreq_w;
  end
  host_model u_host (.mclk_i(mclk_i), .pull_low_i(pull_low), .dereg_req_i(dreq_w),
    .pwr_switch_n_o(sw_n), .dereg_done_o(done));
  pwr_sequencer #(.CYC_PER_MS(CPM)) u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .pwr_switch_n_i(sw_n),
    .module_ready_ind_o(rdy_w), .logic_supply_out_o(sup_w), .int_reset_o(irst_w),
    .power_off_command_i(cmd), .dereg_done_i(done), .dereg_req_o(dreq_w));
  task automatic wms(input int ms);
    repeat (ms * CPM) @(posedge mclk_i);
  endtask : wms
  task automatic chk(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk
  task automatic pulse_cmd;
    cmd <= 1'b1;
    @(posedge mclk_i);
    cmd <= 1'b0;
  endtask : pulse_cmd
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  // Expected levels against ms since the press started
  function automatic logic exp_rdy(input int ms);
    return ms < `T_PULSE_MS || ms >= `T_READY_MS;
  endfunction : exp_rdy
  function automatic logic exp_irst(input int ms);
    return ms >= `T_MIN_LOW_MS && ms < `T_MIN_LOW_MS + `T_IRST_MS;
  endfunction : exp_irst
  initial begin
    int t;
    int len;
    t = 0;
    repeat (12) @(posedge mclk_i);
    reset_i  <= 1'b0;
    pull_low <= 1'b1;
    wms(100);
    pull_low <= 1'b0;
    wms(300);
    chk("early supply", 1'b0, sup);
    chk("early ready", 1'b0, rdy);
    lfsr = lfsr_next(lfsr);
    len = 300 + int'(lfsr % 16'd300);
    pull_low <= 1'b1;
    wms(50);
    chk("short ready pulse", 1'b1, rdy);
    wms(len - 50);
    pull_low <= 1'b0;
    wms(50);
    chk("short supply", 1'b0, sup);
    chk("short ready", 1'b0, rdy);
    wms(100);
    pull_low <= 1'b1;
    foreach (pts[i]) begin
      wms(pts[i] - t);
      t = pts[i];
      chk("ready", exp_rdy(t), rdy);
      chk("int reset", exp_irst(t), irst);
    end
    chk("supply on", 1'b1, sup);
    pulse_cmd();
    wms(10);
    chk("held ready", 1'b1, rdy);
    chk("held dereg", 1'b0, dreq);
    pull_low <= 1'b0;
    wms(5);
    pulse_cmd();
    repeat (4) @(posedge mclk_i);
    chk("off ready", 1'b0, rdy);
    chk("dereg req", 1'b1, dreq);
    for (int i = 0; i < 200 && sup; i++) @(posedge mclk_i);
    chk("supply off", 1'b0, sup);
    chk("ready at off", 1'b0, rdy);
    pull_low <= 1'b1;
    wms(5100);
    chk("hw on ready", 1'b1, rdy);
    wms(5300);
    chk("hw early ready", 1'b1, rdy);
    wms(300);
    chk("hw off ready", 1'b0, rdy);
    chk("hw held supply", 1'b1, sup);
    pull_low <= 1'b0;
    wms(2);
    chk("hw off supply", 1'b0, sup);
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    err_total++;
    $display("[FAIL] watchdog expected finish seen hang");
    wrap_up();
  end
endmodule : pwr_sequencer_test
